//--- inc/wdog_consts.svh
// Offsets, field positions, reset values and counts of the watchdog
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH

// Printed index of the service register; byte address is four times it
`define SVC_INDEX        16'hffff
// Own registers, byte addresses
`define CAUSE_ADDR       18'h0_0000
`define EVT_STATUS_ADDR  18'h0_0004
`define EVT_CLEAR_ADDR   18'h0_0008
`define EVT_ENABLE_ADDR  18'h0_000c
`define STATE_ADDR       18'h0_0010

`define CAUSE_WDOG_BIT   0
`define EVT_TIMEOUT_BIT  0
`define EVT_SERVICE_BIT  1
`define EVT_DISABLE_BIT  2
`define EVT_W            3
`define EVT_ENABLE_RST   3'h0
`define STATE_DIS_BIT    8
`define STATE_DRV_BIT    9

`define CNT_W            6
`define PRESC_FULL_W     12
`define STAGE_KEEP_MASK  12'h007
`define OVF_EARLY        16
`define POR_DELAY_CYCLES 13'h1000
`define PULSE_CYCLES     6'h20
`define MIN_TAP          5

`endif

//--- inc/wdog_pkg.sv
// Types shared by the watchdog modules
package wdog_pkg;
    typedef logic [17:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
    typedef enum logic [1:0] {
        PULSE_IDLE  = 2'b00,
        PULSE_DRIVE = 2'b01,
        PULSE_DONE  = 2'b10
    } pulse_state_e;
endpackage

//--- inc/wdog_if.sv
// Control and count signals between watchdog control and timebase
`timescale 1ns/1ps
interface wdog_if #(parameter int CNT_W = 6);
    logic             clr_all;
    logic             clr_presc;
    logic             clr_upper;
    logic             run;
    logic             rate_fast;
    logic             tick;
    logic             timeout;
    logic [CNT_W-1:0] count;
    modport timebase (input clr_all, clr_presc, clr_upper, run, rate_fast,
                      output tick, timeout, count);
    modport ctrl (output clr_all, clr_presc, clr_upper, run, rate_fast,
                  input tick, timeout, count);
endinterface

//--- logic/wdog_timebase.sv
// Watchdog prescaler and 6-bit timeout counter
`timescale 1ns/1ps
`include "wdog_consts.svh"
module wdog_timebase #(
    parameter int PRESC_W  = 12,
    parameter int FAST_TAP = 7
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    wdog_if.timebase tb
);
    localparam logic [PRESC_W-1:0] SLOW_MASK = {PRESC_W{1'b1}};
    localparam logic [PRESC_W-1:0] FAST_MASK = SLOW_MASK >> (PRESC_W - FAST_TAP);
    localparam logic [PRESC_W-1:0] KEEP_MASK = PRESC_W'(`STAGE_KEEP_MASK);
    localparam logic [PRESC_W-1:0] EARLY     = PRESC_W'(`OVF_EARLY);

    logic [PRESC_W-1:0]  presc_r;
    logic [PRESC_W-1:0]  mask;
    logic [PRESC_W-1:0]  phase;
    logic [`CNT_W-1:0]   cnt_r;

    assign mask  = tb.rate_fast ? FAST_MASK : SLOW_MASK;
    assign phase = presc_r & mask;
    // Counter advances when the selected prescaler stages roll over
    assign tb.tick    = tb.run & (phase == mask);
    // Overflow lands 16 cycles before the 64th tick
    assign tb.timeout = tb.run & (&cnt_r) & (phase == (mask - EARLY));
    assign tb.count   = cnt_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || tb.clr_presc) begin
            presc_r <= '0;
        end else if (tb.clr_upper) begin
            presc_r <= presc_r & KEEP_MASK;
        end else if (tb.run) begin
            presc_r <= presc_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || tb.clr_all || tb.clr_upper) begin
            cnt_r <= '0;
        end else if (tb.tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule

//--- logic/runaway_code_watchdog.sv
// Runaway-code watchdog with APB registers and reset pin driver
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "wdog_consts.svh"

// Functional notes
// - 6-bit counter fed by 12-bit prescaler
// - Overflow after 8176 or 262128 cycles
// - Service write clears counter, prescaler stages 4-12
// - Service read returns reset vector low byte
// - Timeout: reset pin low 32 cycles, flag
// - STOP instruction clears prescaler
// - Prescaler cleared 4096 cycles after power-up
// - Internal reset clears prescaler and counter
// - Reset vector fetch clears prescaler
// - Disable input blocks reset; rate input selects
// - Monitor mode with high voltage disables
// - Break with high voltage on reset disables
// - Never a CPU interrupt; only reset
// - Keeps counting in wait mode
// - Stop mode gates clock, clears prescaler
module runaway_code_watchdog #(
    parameter int TIMEOUT_FAST = 8176,
    parameter int TIMEOUT_SLOW = 262128
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire wdog_pkg::apb_addr_t paddr,
    input  wire wdog_pkg::apb_data_t pwdata,
    output wire wdog_pkg::apb_data_t prdata,
    output wire logic                pready,
    output wire logic                pslverr,
    input  wire logic [7:0]          reset_vector_low,
    input  wire logic                timeout_rate_select,
    input  wire logic                watchdog_disable,
    input  wire logic                monitor_mode,
    input  wire logic                break_active,
    input  wire logic                irq_pin_high_voltage,
    input  wire logic                rst_pin_high_voltage,
    input  wire logic                wait_mode,
    input  wire logic                stop_mode,
    input  wire logic                stop_exec,
    input  wire logic                vector_fetch,
    input  wire logic                internal_reset,
    output wire logic                rst_pin_o,
    output wire logic                rst_pin_oe,
    output wire logic                system_reset_req,
    output wire logic                irq
);
    import wdog_pkg::*;

    localparam int FAST_TAP = $clog2((TIMEOUT_FAST + `OVF_EARLY) / 64);
    localparam int SLOW_TAP = $clog2((TIMEOUT_SLOW + `OVF_EARLY) / 64);

    // Timeouts must be 64 prescaler periods less 16
    if ((64 * (1 << FAST_TAP) - `OVF_EARLY) != TIMEOUT_FAST) begin : g_chk_fast
        $error("TIMEOUT_FAST is not 64 * 2**n - 16");
    end
    if ((64 * (1 << SLOW_TAP) - `OVF_EARLY) != TIMEOUT_SLOW) begin : g_chk_slow
        $error("TIMEOUT_SLOW is not 64 * 2**n - 16");
    end
    if (FAST_TAP < `MIN_TAP || SLOW_TAP <= FAST_TAP || SLOW_TAP > `PRESC_FULL_W) begin : g_chk_tap
        $error("Timeout taps out of range");
    end

    function automatic logic hit(input apb_addr_t a, input apb_addr_t b);
        return a == b;
    endfunction

    localparam apb_addr_t SVC_ADDR = {`SVC_INDEX, 2'b00};

    // Bus state
    logic              setup_rd;
    logic              access;
    logic              wr_en;
    logic              rd_done;
    logic              svc_write;
    logic              map_hit;
    apb_data_t         rd_value;
    apb_data_t         prdata_r;
    logic              pslverr_r;

    // Watchdog state
    logic              disabled;
    logic              disabled_d_r;
    logic [12:0]       por_cnt_r;
    logic              por_done_r;
    logic              por_clear;
    pulse_state_e      pulse_r;
    pulse_state_e      pulse_nxt;
    logic [5:0]        pulse_cnt_r;
    logic              cause_r;
    logic [`EVT_W-1:0] evt_status_r;
    logic [`EVT_W-1:0] evt_enable_r;
    logic [`EVT_W-1:0] evt_set;
    logic [`EVT_W-1:0] evt_clr;
    logic              fire;

    wdog_if #(.CNT_W(`CNT_W)) tb_if ();

    // Disable sources
    assign disabled = watchdog_disable
                    | (monitor_mode & (irq_pin_high_voltage | rst_pin_high_voltage))
                    | (break_active & rst_pin_high_voltage);

    // Power-on delay before the prescaler is cleared once
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            por_cnt_r  <= '0;
            por_done_r <= 1'b0;
        end else if (!por_done_r) begin
            por_cnt_r  <= por_cnt_r + 1'b1;
            por_done_r <= (por_cnt_r == `POR_DELAY_CYCLES - 13'h0001);
        end
    end
    assign por_clear = !por_done_r && (por_cnt_r == `POR_DELAY_CYCLES - 13'h0001);

    // Timebase control
    assign tb_if.rate_fast = timeout_rate_select;
    // Wait mode leaves the timebase running
    assign tb_if.run = !stop_mode && !disabled;
    assign tb_if.clr_upper = svc_write;
    assign tb_if.clr_presc = stop_exec
                           | stop_mode
                           | por_clear
                           | vector_fetch
                           | internal_reset
                           | disabled
                           | (pulse_r != PULSE_IDLE);
    assign tb_if.clr_all = internal_reset
                         | disabled
                         | (pulse_r != PULSE_IDLE);

    wdog_timebase #(
        .PRESC_W  (SLOW_TAP),
        .FAST_TAP (FAST_TAP)
    ) u_timebase (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .tb      (tb_if.timebase)
    );

    assign fire = (pulse_r == PULSE_IDLE) && tb_if.timeout && !disabled;

    // Reset pulse sequencer
    always_comb begin
        pulse_nxt = pulse_r;
        unique case (pulse_r)
            PULSE_IDLE: begin
                if (fire) begin
                    pulse_nxt = PULSE_DRIVE;
                end
            end
            PULSE_DRIVE: begin
                if (pulse_cnt_r == `PULSE_CYCLES - 6'h01) begin
                    pulse_nxt = PULSE_DONE;
                end
            end
            PULSE_DONE: begin
                pulse_nxt = PULSE_IDLE;
            end
            default: begin
                pulse_nxt = PULSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pulse_r <= PULSE_IDLE;
        end else begin
            pulse_r <= pulse_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || pulse_r != PULSE_DRIVE) begin
            pulse_cnt_r <= '0;
        end else begin
            pulse_cnt_r <= pulse_cnt_r + 6'h01;
        end
    end

    // Open-drain reset pin, driven low only
    assign rst_pin_o        = 1'b0;
    assign rst_pin_oe       = (pulse_r == PULSE_DRIVE);
    // Reset is the only request a timeout makes; it also sets the cause flag
    assign system_reset_req = (pulse_r == PULSE_DRIVE);

    // APB decode
    assign setup_rd  = psel && !penable && !pwrite;
    assign access    = psel && penable;
    assign wr_en     = access && pwrite;
    assign rd_done   = access && !pwrite;
    assign svc_write = wr_en && hit(paddr, SVC_ADDR);
    assign map_hit   = hit(paddr, SVC_ADDR)
                     | hit(paddr, `CAUSE_ADDR)
                     | hit(paddr, `EVT_STATUS_ADDR)
                     | hit(paddr, `EVT_CLEAR_ADDR)
                     | hit(paddr, `EVT_ENABLE_ADDR)
                     | hit(paddr, `STATE_ADDR);
    assign pready    = access;

    always_comb begin
        rd_value = '0;
        if (hit(paddr, SVC_ADDR)) begin
            rd_value[7:0] = reset_vector_low;
        end else if (hit(paddr, `CAUSE_ADDR)) begin
            rd_value[`CAUSE_WDOG_BIT] = cause_r;
        end else if (hit(paddr, `EVT_STATUS_ADDR)) begin
            rd_value[`EVT_W-1:0] = evt_status_r;
        end else if (hit(paddr, `EVT_ENABLE_ADDR)) begin
            rd_value[`EVT_W-1:0] = evt_enable_r;
        end else if (hit(paddr, `STATE_ADDR)) begin
            rd_value[`CNT_W-1:0]     = tb_if.count;
            rd_value[`STATE_DIS_BIT] = disabled;
            rd_value[`STATE_DRV_BIT] = (pulse_r == PULSE_DRIVE);
        end
    end

    // Read data captured in setup, stable through access
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata_r <= '0;
        end else if (setup_rd) begin
            prdata_r <= rd_value;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_r <= !map_hit;
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = access && pslverr_r;

    // Cause flag: clears on read of a set value, set wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cause_r <= 1'b0;
        end else if (fire) begin
            cause_r <= 1'b1;
        end else if (rd_done && hit(paddr, `CAUSE_ADDR) && prdata_r[`CAUSE_WDOG_BIT]) begin
            cause_r <= 1'b0;
        end
    end

    // Event status, clear and enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            disabled_d_r <= 1'b0;
        end else begin
            disabled_d_r <= disabled;
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[`EVT_TIMEOUT_BIT] = fire;
        evt_set[`EVT_SERVICE_BIT] = svc_write;
        evt_set[`EVT_DISABLE_BIT] = disabled && !disabled_d_r;
    end

    assign evt_clr = (wr_en && hit(paddr, `EVT_CLEAR_ADDR)) ? pwdata[`EVT_W-1:0] : '0;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            evt_status_r <= '0;
        end else begin
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            evt_enable_r <= `EVT_ENABLE_RST;
        end else if (wr_en && hit(paddr, `EVT_ENABLE_ADDR)) begin
            evt_enable_r <= pwdata[`EVT_W-1:0];
        end
    end

    // Bus-side status line, not a CPU request of the watchdog
    assign irq = |(evt_status_r & evt_enable_r);

endmodule

//--- test/cpu_bus_model.sv
// APB master standing in for the CPU core that services the watchdog
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic                sys_clk,
    output logic                     psel,
    output logic                     penable,
    output logic                     pwrite,
    output wdog_pkg::apb_addr_t      paddr,
    output wdog_pkg::apb_data_t      pwdata,
    input  wire wdog_pkg::apb_data_t prdata,
    input  wire logic                pready,
    input  wire logic                pslverr
);
    import wdog_pkg::*;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Request held unchanged until pready is seen at a rising edge
    task automatic xfer(input logic w, input apb_addr_t a, input apb_data_t d,
                        output apb_data_t rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- test/wdog_asserts.sv
// Port-level checks on the watchdog top module
`timescale 1ns/1ps
`include "wdog_consts.svh"
module wdog_asserts #(
    parameter int TIMEOUT_FAST = 8176
) (
    input wire logic                sys_clk,
    input wire logic                sys_rst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire wdog_pkg::apb_addr_t paddr,
    input wire wdog_pkg::apb_data_t prdata,
    input wire logic                pready,
    input wire logic [7:0]          reset_vector_low,
    input wire logic                watchdog_disable,
    input wire logic                monitor_mode,
    input wire logic                break_active,
    input wire logic                irq_pin_high_voltage,
    input wire logic                rst_pin_high_voltage,
    input wire logic                stop_mode,
    input wire logic                internal_reset,
    input wire logic                rst_pin_o,
    input wire logic                rst_pin_oe,
    input wire logic                system_reset_req
);
    import wdog_pkg::*;
    localparam int MIN_RUN = TIMEOUT_FAST - 16;
    logic [5:0]  oe_cnt_r;
    logic [31:0] run_cnt_r;
    logic        svc_wr;
    logic        held;
    logic        mon_off;
    logic        brk_off;

    assign svc_wr = psel && penable && pwrite && paddr == {`SVC_INDEX, 2'b00};
    assign mon_off = monitor_mode && (irq_pin_high_voltage || rst_pin_high_voltage);
    assign brk_off = break_active && rst_pin_high_voltage;
    assign held = svc_wr || internal_reset || watchdog_disable || stop_mode || rst_pin_oe || mon_off || brk_off;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !rst_pin_oe) oe_cnt_r <= 6'h00;
        else oe_cnt_r <= oe_cnt_r + 6'h01;
    end
    // Cycles of free running since the last event that clears the count
    always_ff @(posedge sys_clk) begin
        if (sys_rst || held) run_cnt_r <= '0;
        else run_cnt_r <= run_cnt_r + 32'h0000_0001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_pin_drive_low: assert property (rst_pin_oe |-> !rst_pin_o)
        else $error("Reset pin driven high during pulse");
    chk_req_follows_pin: assert property (system_reset_req == rst_pin_oe)
        else $error("Reset request differs from pin drive");
    chk_pulse_max_len: assert property (rst_pin_oe |-> oe_cnt_r < 6'h20)
        else $error("Reset pulse too long");
    chk_pulse_full_len: assert property ($fell(rst_pin_oe) |-> $past(oe_cnt_r) == 6'h1f)
        else $error("Reset pulse too short");
    chk_no_early_reset: assert property ($rose(rst_pin_oe) |-> run_cnt_r >= MIN_RUN)
        else $error("Timeout before the counted period");
    chk_disable_quiet: assert property (watchdog_disable && $past(watchdog_disable) |-> !$rose(rst_pin_oe))
        else $error("Reset while disabled");
    chk_monitor_quiet: assert property (mon_off && $past(mon_off) |-> !$rose(rst_pin_oe))
        else $error("Reset in monitor mode with test voltage");
    chk_break_quiet: assert property (brk_off && $past(brk_off) |-> !$rose(rst_pin_oe))
        else $error("Reset in break with test voltage");
    chk_stop_quiet: assert property (stop_mode && $past(stop_mode) |-> !$rose(rst_pin_oe))
        else $error("Reset while stopped");
    chk_vector_read: assert property (psel && penable && !pwrite && paddr == {`SVC_INDEX, 2'b00}
        |-> prdata[7:0] == reset_vector_low)
        else $error("Service read not the vector byte");
    chk_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("Access phase not answered");

    cov_timeout: cover property ($rose(rst_pin_oe));
    cov_service: cover property (svc_wr);
    cov_disabled: cover property (watchdog_disable ##1 watchdog_disable);
endmodule

bind runaway_code_watchdog wdog_asserts #(.TIMEOUT_FAST(TIMEOUT_FAST)) i_chk (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .reset_vector_low,
    .watchdog_disable, .monitor_mode, .break_active, .irq_pin_high_voltage, .rst_pin_high_voltage,
    .stop_mode, .internal_reset, .rst_pin_o, .rst_pin_oe, .system_reset_req);

//--- test/runaway_code_watchdog_tb.sv
// Self-checking bench for the runaway-code watchdog
`timescale 1ns/1ps
`include "wdog_consts.svh"
module runaway_code_watchdog_tb;
    import wdog_pkg::*;
    localparam int FAST = 2032;
    localparam int SLOW = 8176;
    localparam apb_addr_t SVC = {`SVC_INDEX, 2'b00};
    typedef struct packed {
        logic      w;
        apb_addr_t a;
        apb_data_t d;
        apb_data_t x;
        logic      e;
    } row_s;
    row_s       rows [8];
    logic       sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
    apb_addr_t  paddr;
    apb_data_t  pwdata, prdata, rd;
    logic [7:0] reset_vector_low;
    logic       timeout_rate_select, watchdog_disable, monitor_mode, break_active;
    logic       irq_pin_high_voltage, rst_pin_high_voltage, wait_mode, stop_mode;
    logic       stop_exec, vector_fetch, internal_reset, rst_pin_o, rst_pin_oe, system_reset_req, irq;
    int         n, m, cyc, tests_run, fail_count;

    runaway_code_watchdog #(.TIMEOUT_FAST(FAST), .TIMEOUT_SLOW(SLOW)) i_dut (
        .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .reset_vector_low, .timeout_rate_select, .watchdog_disable, .monitor_mode, .break_active,
        .irq_pin_high_voltage, .rst_pin_high_voltage, .wait_mode, .stop_mode, .stop_exec,
        .vector_fetch, .internal_reset, .rst_pin_o, .rst_pin_oe, .system_reset_req, .irq);
    cpu_bus_model i_cpu (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 45000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic bus(input logic w, input apb_addr_t a, input apb_data_t d);
        i_cpu.xfer(w, a, d, rd, er);
    endtask
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (!ok) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic pause(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_oe(input int lim, output int cnt);
        cnt = 0;
        while (rst_pin_oe !== 1'b1 && cnt < lim) begin
            pause(1);
            cnt++;
        end
    endtask
    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic set_off(input int k);
        @(posedge sys_clk);
        watchdog_disable <= (k == 0);
        monitor_mode <= (k == 1);
        irq_pin_high_voltage <= (k == 1);
        break_active <= (k == 2);
        rst_pin_high_voltage <= (k == 2);
        stop_mode <= (k == 3);
    endtask

    initial begin
        rows = '{'{1'b0, `EVT_ENABLE_ADDR, '0, '0, 1'b0}, '{1'b1, `EVT_ENABLE_ADDR, 32'h0000_0001, '0, 1'b0},
                 '{1'b0, `EVT_ENABLE_ADDR, '0, 32'h0000_0001, 1'b0}, '{1'b0, `EVT_CLEAR_ADDR, '0, '0, 1'b0},
                 '{1'b0, `EVT_STATUS_ADDR, '0, 32'h0000_0002, 1'b0}, '{1'b0, SVC, '0, 32'h0000_005a, 1'b0},
                 '{1'b0, 18'h0_0020, '0, '0, 1'b1}, '{1'b1, 18'h0_0020, 32'h0000_0001, '0, 1'b1}};
        {sys_rst, timeout_rate_select} = 2'b11;
        {watchdog_disable, monitor_mode, break_active, irq_pin_high_voltage, rst_pin_high_voltage} = '0;
        {wait_mode, stop_mode, stop_exec, vector_fetch, internal_reset} = '0;
        reset_vector_low = 8'h5a;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus(1'b1, SVC, '0);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            check((rows[i].w || rd === rows[i].x) && er === rows[i].e, "register row");
        end
        for (int k = 0; k < 4; k++) begin
            set_off(k);
            wait_oe(2600, n);
            check(n == 2600, "reset while held off");
            bus(1'b0, `STATE_ADDR, '0);
            check(k == 3 || (rd[8] === 1'b1 && rd[5:0] === 6'h00), "disabled count not cleared");
        end
        set_off(4);
        wait_mode <= 1'b1;
        bus(1'b1, SVC, '0);
        wait_oe(2200, n);
        check(n >= FAST - 16 && n <= FAST + 2, "fast timeout length");
        check(rst_pin_o === 1'b0 && system_reset_req === 1'b1 && irq === 1'b1, "reset outputs");
        m = 0;
        while (rst_pin_oe === 1'b1 && m < 40) begin
            pause(1);
            m++;
        end
        check(m == 32, "reset pulse length");
        bus(1'b0, `CAUSE_ADDR, '0);
        check(rd === 32'h0000_0001, "cause flag not set");
        bus(1'b0, `CAUSE_ADDR, '0);
        check(rd === '0, "cause flag not cleared");
        bus(1'b1, `EVT_ENABLE_ADDR, '0);
        pause(2);
        check(irq === 1'b0, "irq not masked");
        bus(1'b1, `EVT_ENABLE_ADDR, 32'h0000_0001);
        pause(2);
        check(irq === 1'b1, "irq not raised");
        bus(1'b1, `EVT_CLEAR_ADDR, 32'h0000_0001);
        pause(2);
        check(irq === 1'b0, "irq not cleared");
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, SVC, '0);
            wait_oe(1500, n);
            check(n == 1500, "reset despite service");
        end
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, SVC, '0);
            {stop_exec, vector_fetch} <= (k == 0) ? 2'b10 : 2'b01;
            pause(100);
            bus(1'b0, `STATE_ADDR, '0);
            {stop_exec, vector_fetch} <= 2'b00;
            check(rd[5:0] === 6'h00, "prescaler clear let count advance");
        end
        @(posedge sys_clk);
        internal_reset <= 1'b1;
        bus(1'b0, `STATE_ADDR, '0);
        check(rd[5:0] === 6'h00, "internal reset kept count");
        internal_reset <= 1'b0;
        wait_oe(2200, n);
        check(n >= FAST - 16 && n <= FAST + 2, "internal reset did not restart count");
        pause(40);
        @(posedge sys_clk);
        timeout_rate_select <= 1'b0;
        bus(1'b1, SVC, '0);
        wait_oe(8300, n);
        check(n >= SLOW - 16 && n <= SLOW + 2, "slow timeout length");
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        pause(3);
        check(rst_pin_oe === 1'b0 && system_reset_req === 1'b0 && irq === 1'b0 && prdata === '0, "reset outputs");
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus(1'b0, `CAUSE_ADDR, '0);
        check(rd === '0 && rst_pin_oe === 1'b0, "cause flag kept over reset");
        give_verdict();
    end
endmodule
